// File: rtl/asi_pkg.sv
// Package for the asynchronous serial interface block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package asi_pkg;
  // Register byte offsets.
  localparam logic [7:0] ASI_OFF_STATUS = 8'h00; // Status register.
  localparam logic [7:0] ASI_OFF_DATA   = 8'h04; // Data buffer register.
  localparam logic [7:0] ASI_OFF_CTL1   = 8'h08; // Control register one.
  localparam logic [7:0] ASI_OFF_CTL2   = 8'h0C; // Control register two.
  localparam logic [7:0] ASI_OFF_BAUD   = 8'h10; // Baud select register.
  // Status bit positions.
  localparam int ASI_ST_TXE  = 7; // Transmit buffer empty.
  localparam int ASI_ST_TC   = 6; // Transmission complete.
  localparam int ASI_ST_RXF  = 5; // Receive buffer full.
  localparam int ASI_ST_IDLE = 4; // Idle line seen.
  localparam int ASI_ST_OR   = 3; // Overrun.
  localparam int ASI_ST_NF   = 2; // Noise.
  localparam int ASI_ST_FE   = 1; // Framing error.
  // Control one bit positions.
  localparam int ASI_C1_RX8  = 7; // Received ninth bit.
  localparam int ASI_C1_TX8  = 6; // Ninth bit to send.
  localparam int ASI_C1_M    = 4; // Nine-bit word select.
  // Control two bit positions.
  localparam int ASI_C2_TIE  = 7; // Buffer empty interrupt enable.
  localparam int ASI_C2_TX_DONE_IRQ_ON = 6; // Complete interrupt enable.
  localparam int ASI_C2_RIE  = 5; // Receive interrupt enable.
  localparam int ASI_C2_IDLE_IRQ_ON = 4; // Idle interrupt enable.
  localparam int ASI_C2_TE   = 3; // Transmitter on.
  localparam int ASI_C2_RE   = 2; // Receiver on.
  localparam int ASI_C2_SBK  = 0; // Send break.
  // Reset values.
  localparam logic [7:0] ASI_RST_STATUS = 8'hC0; // Empty and complete.
  localparam logic [7:0] ASI_RST_CTL    = 8'h00; // All controls off.
  // Oversampling figures.
  localparam logic [3:0] ASI_OVS_LAST  = 4'hF; // Sixteen samples per bit.
  localparam logic [3:0] ASI_SMP_A     = 4'h7; // Eighth sample.
  localparam logic [3:0] ASI_SMP_C     = 4'h9; // Tenth sample.
  localparam logic [3:0] ASI_HALF_BIT  = 4'h7; // Start check point.
  // Transmit bit index of stop bit per word length.
  localparam logic [3:0] ASI_LEN8 = 4'h9; // Start, 8 data, stop.
  localparam logic [3:0] ASI_LEN9 = 4'hA; // Start, 9 data, stop.
  // Transmitter states.
  typedef enum logic [1:0] {
    ASI_TX_OFF  = 2'b00,
    ASI_TX_IDLE = 2'b01,
    ASI_TX_SEND = 2'b10
  } asi_tx_st_t;
  // Receiver states.
  typedef enum logic [1:0] {
    ASI_RX_HUNT  = 2'b00,
    ASI_RX_START = 2'b01,
    ASI_RX_DATA  = 2'b10
  } asi_rx_st_t;
endpackage

// File: rtl/asi_core.sv
// Asynchronous serial interface with AHB-Lite register access.
// Assumes serial_in_pin is already synchronous to hclk.
// Contract
// - Enabled and idle: output pin high
// - Both off: pin released to port
// - Frame: start low, data LSB first, stop
// - Nine-bit mode sends tx_ninth_bit as MSB
// - Nine-bit mode stores rx_ninth_bit
// - Enabling transmitter sends one idle frame
// - TE toggle: idle after word, drop buffer
// - Break frames while set, then one high
// - Busy write goes to holding buffer
// - Idle write loads shifter, sets empty flag
// - Empty flag clears: status then write
// - Interrupt on empty flag when enabled
// - Complete flag after stop or break
// - Complete flag clears like empty flag
// - Receiver on starts start-bit hunt
// - Character moves to buffer, sets full
// - Full flag clears: status then read
// - Full still set: overrun, keep buffer
// - Overrun clears: status then read
// - Break received reported as framing error
// - Idle frame flagged, optional interrupt
// - Idle is full frame of ones
// - Majority of samples 8-10, noise flag
// - Baud: clock/16/prescaler/power of two
// - Missing stop: framing error, data kept
`timescale 1ns/1ps
module asi_core
  import asi_pkg::*;
#(
  parameter int DIV_W = 12 // Width of the baud divide counter.
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_in_pin,
  output logic             serial_out,
  output logic             serial_out_en_n,
  output logic             irq
);
  // Whole block state held in one packed record.
  typedef struct packed {
    logic             wr_pend;   // Data phase of a write pending.
    logic             rd_pend;   // Data phase of a read pending.
    logic [7:0]       addr;      // Latched register offset.
    logic [31:0]      rdata;     // Read data out.
    logic [7:0]       status;    // Status flags.
    logic             st_seen;   // Status was read since last clear.
    logic [7:0]       ctl1;      // Control register one.
    logic [7:0]       ctl2;      // Control register two.
    logic [7:0]       baud;      // Baud select register.
    logic [DIV_W-1:0] tx_div;    // Transmit tick divider.
    logic [DIV_W-1:0] rx_div;    // Receive tick divider.
    asi_tx_st_t       tx_st;     // Transmitter state.
    logic [3:0]       tx_ovs;    // Transmit sixteenth counter.
    logic [3:0]       tx_bit;    // Transmit bit index.
    logic [10:0]      tx_sh;     // Transmit frame shifter.
    logic [8:0]       tx_hold;   // Holding buffer.
    logic             tx_full;   // Holding buffer occupied.
    logic             tx_brk;    // Current frame is a break.
    logic             tx_idle;   // Idle frame owed.
    logic             tx_mark;   // Extra high bit owed after break.
    logic             te_off;    // Transmitter was switched off.
    asi_rx_st_t       rx_st;     // Receiver state.
    logic [3:0]       rx_ovs;    // Receive sixteenth counter.
    logic [3:0]       rx_bit;    // Receive bit index.
    logic [9:0]       rx_sh;     // Receive shifter.
    logic [2:0]       rx_smp;    // Samples eight to ten.
    logic             rx_noise;  // Noise seen in this frame.
    logic [3:0]       ones;      // Count of high bits for idle.
    logic             idle_arm;  // Line went low since last idle.
    logic [8:0]       rx_buf;    // Receive holding buffer.
    logic             out;       // Serial output register.
    logic             oen_n;     // Output enable, low drives.
    logic             irq;       // Interrupt register.
  } asi_st_t;

  asi_st_t q, d;

  logic             tx_tick, rx_tick; // Sixteenth-bit ticks.
  logic [DIV_W-1:0] div_load;         // Divide count minus one.
  logic [3:0]       flen;             // Stop bit index.
  logic             maj;              // Majority of three samples.
  logic             noisy;            // Samples disagree.

  // Prescaler times power of two, giving cycles per sixteenth bit.
  always_comb
  begin
    logic [7:0] pr;
    pr = 8'h01;
    case (q.baud[7:6])
      2'b00:   pr = 8'h01;
      2'b01:   pr = 8'h03;
      2'b10:   pr = 8'h04;
      default: pr = 8'h0D;
    endcase
    div_load = DIV_W'(({4'h0, pr} << q.baud[2:0]) - 12'h001);
  end

  // Separate tick outputs of the two dividers.
  assign tx_tick = (q.tx_div == '0);
  assign rx_tick = (q.rx_div == '0);
  assign flen    = q.ctl1[ASI_C1_M] ? ASI_LEN9 : ASI_LEN8;
  assign maj     = (q.rx_smp[0] & q.rx_smp[1]) | (q.rx_smp[1] & q.rx_smp[2])
                 | (q.rx_smp[0] & q.rx_smp[2]);
  assign noisy   = !(&q.rx_smp) && (|q.rx_smp);

  // Next state of bus, transmitter and receiver.
  always_comb
  begin
    logic data_wr, data_rd, st_rd, te, re, rx_done, idle_hit;
    logic [8:0] wv;
    d = q;
    data_wr = q.wr_pend && q.addr == ASI_OFF_DATA;
    data_rd = q.rd_pend && q.addr == ASI_OFF_DATA;
    st_rd   = q.rd_pend && q.addr == ASI_OFF_STATUS;
    te      = q.ctl2[ASI_C2_TE];
    re      = q.ctl2[ASI_C2_RE];
    rx_done = 1'b0;
    idle_hit = 1'b0;
    // Eight-bit mode puts a stop level where the ninth bit would go.
    wv      = {q.ctl1[ASI_C1_M] ? q.ctl1[ASI_C1_TX8] : 1'b1,
               hwdata[7:0]};
    // Bus address phase: register a single word transfer.
    d.wr_pend = 1'b0;
    d.rd_pend = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      d.wr_pend = hwrite;
      d.rd_pend = !hwrite;
      d.addr    = haddr[7:0];
    end
    // Read data for the next data phase; unmapped reads give zero.
    d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr[7:0])
        ASI_OFF_STATUS: d.rdata = {24'h0, q.status};
        ASI_OFF_DATA:   d.rdata = {24'h0, q.rx_buf[7:0]};
        ASI_OFF_CTL1:   d.rdata = {24'h0, q.ctl1};
        ASI_OFF_CTL2:   d.rdata = {24'h0, q.ctl2};
        ASI_OFF_BAUD:   d.rdata = {24'h0, q.baud};
        default:        d.rdata = 32'h0000_0000;
      endcase
    end
    // Status read arms the clearing sequences.
    if (st_rd)
      d.st_seen = 1'b1;
    // Register writes in the data phase.
    if (q.wr_pend)
    begin
      case (q.addr)
        ASI_OFF_CTL1: d.ctl1 = {q.ctl1[7], hwdata[6:0]};
        ASI_OFF_CTL2:
        begin
          d.ctl2 = hwdata[7:0];
          // Only a switch-off in mid-frame sets te_off; an idle one goes through ASI_TX_OFF.
          if (te && !hwdata[ASI_C2_TE] && q.tx_st == ASI_TX_SEND)
            d.te_off = 1'b1;
        end
        ASI_OFF_BAUD: d.baud = hwdata[7:0];
        default:      d.baud = q.baud;
      endcase
    end
    // Baud dividers reload independently.
    d.tx_div = tx_tick ? div_load : q.tx_div - 1'b1;
    d.rx_div = rx_tick ? div_load : q.rx_div - 1'b1;

    // Data write: clear flags only after a status read.
    if (data_wr)
    begin
      if (q.st_seen)
      begin
        d.status[ASI_ST_TXE] = 1'b0;
        d.status[ASI_ST_TC]  = 1'b0;
        d.st_seen = 1'b0;
      end
      if (te && q.tx_st != ASI_TX_SEND)
      begin
        // Idle transmitter: load shifter directly.
        d.tx_sh  = {1'b1, wv, 1'b0};
        d.tx_st  = ASI_TX_SEND;
        d.tx_bit = 4'h0;
        d.tx_ovs = 4'h0;
        d.tx_brk = 1'b0;
        d.status[ASI_ST_TXE] = 1'b1;
      end
      else
      begin
        d.tx_hold = wv;
        d.tx_full = 1'b1;
      end
    end

    // Transmitter sequencing.
    case (q.tx_st)
      ASI_TX_OFF:
      begin
        if (te)
        begin
          d.tx_st   = ASI_TX_SEND;
          d.tx_sh   = 11'h7FF;
          d.tx_bit  = 4'h0;
          d.tx_ovs  = 4'h0;
          d.tx_brk  = 1'b0;
          d.tx_full = 1'b0;
        end
      end
      ASI_TX_IDLE:
      begin
        if (!te)
          d.tx_st = ASI_TX_OFF;
        else if (q.ctl2[ASI_C2_SBK])
        begin
          d.tx_st  = ASI_TX_SEND;
          d.tx_sh  = 11'h000;
          d.tx_brk = 1'b1;
          d.tx_bit = 4'h0;
          d.tx_ovs = 4'h0;
        end
        else if (q.tx_mark || q.tx_full)
        begin
          d.tx_st   = ASI_TX_SEND;
          d.tx_sh   = q.tx_mark ? 11'h7FF : {1'b1, q.tx_hold, 1'b0};
          d.tx_bit  = q.tx_mark ? flen : 4'h0;
          d.tx_ovs  = 4'h0;
          d.tx_brk  = 1'b0;
          d.tx_full = q.tx_mark ? q.tx_full : 1'b0;
          d.tx_mark = 1'b0;
          if (!q.tx_mark)
            d.status[ASI_ST_TXE] = 1'b1;
        end
      end
      default:
      begin
        if (tx_tick)
        begin
          d.tx_ovs = q.tx_ovs + 1'b1;
          if (q.tx_ovs == ASI_OVS_LAST)
          begin
            d.tx_sh  = {1'b1, q.tx_sh[10:1]};
            d.tx_bit = q.tx_bit + 1'b1;
            if (q.tx_bit == flen)
            begin
              // Frame ends: re-enabled transmitter owes idle frame.
              d.tx_st = ASI_TX_IDLE;
              if (q.tx_brk)
                d.tx_mark = !q.ctl2[ASI_C2_SBK];
              if (!q.tx_full || q.tx_brk)
                d.status[ASI_ST_TC] = 1'b1;
              if (q.te_off)
              begin
                d.te_off  = 1'b0;
                d.tx_st   = te ? ASI_TX_SEND : ASI_TX_OFF;
                d.tx_sh   = 11'h7FF;
                d.tx_bit  = 4'h0;
                d.tx_brk  = 1'b0;
                d.tx_full = 1'b0;
              end
            end
          end
        end
      end
    endcase
    // Pin drive: high when idle, released when both off.
    d.out   = (q.tx_st == ASI_TX_SEND) ? q.tx_sh[0] : 1'b1;
    d.oen_n = !(te || re);

    // Receiver sampling.
    if (!re)
      d.rx_st = ASI_RX_HUNT;
    else if (rx_tick)
    begin
      d.rx_ovs = q.rx_ovs + 1'b1;
      if (q.rx_ovs >= ASI_SMP_A && q.rx_ovs <= ASI_SMP_C)
        d.rx_smp = {serial_in_pin, q.rx_smp[2:1]};
      case (q.rx_st)
        ASI_RX_HUNT:
        begin
          if (!serial_in_pin)
          begin
            d.rx_st    = ASI_RX_START;
            d.rx_ovs   = 4'h0;
            d.idle_arm = 1'b1;
            d.rx_noise = 1'b0;
          end
          else if (q.rx_ovs == ASI_OVS_LAST && q.ones != 4'hF)
            d.ones = q.ones + 1'b1; // Counts whole high bit times.
        end
        ASI_RX_START:
        begin
          if (q.rx_ovs == ASI_OVS_LAST)
          begin
            d.rx_st  = maj ? ASI_RX_HUNT : ASI_RX_DATA;
            d.rx_bit = 4'h1;
            d.rx_noise = noisy;
            d.ones   = 4'h0;
          end
        end
        default:
        begin
          if (q.rx_ovs == ASI_OVS_LAST)
          begin
            d.rx_sh  = {maj, q.rx_sh[9:1]};
            d.rx_bit = q.rx_bit + 1'b1;
            if (noisy)
              d.rx_noise = 1'b1;
            if (q.rx_bit == flen)
            begin
              d.rx_st = ASI_RX_HUNT;
              rx_done = 1'b1;
            end
          end
        end
      endcase
      // A whole frame of ones after traffic counts as idle.
      if (q.rx_st == ASI_RX_HUNT && q.idle_arm && serial_in_pin
          && q.ones == flen && q.rx_ovs == ASI_OVS_LAST)
      begin
        idle_hit   = 1'b1;
        d.idle_arm = 1'b0;
      end
    end

    // Software clears of receive flags: status then data read.
    if (data_rd && q.st_seen)
    begin
      d.status[ASI_ST_RXF]  = 1'b0;
      d.status[ASI_ST_OR]   = 1'b0;
      d.status[ASI_ST_NF]   = 1'b0;
      d.status[ASI_ST_FE]   = 1'b0;
      d.status[ASI_ST_IDLE] = 1'b0;
      d.st_seen = 1'b0;
    end
    // Idle detection is applied after the clear so that the set wins.
    if (idle_hit)
      d.status[ASI_ST_IDLE] = 1'b1;
    // Character completion; hardware set wins over the clear.
    if (rx_done)
    begin
      if (q.status[ASI_ST_RXF] && !(data_rd && q.st_seen))
        d.status[ASI_ST_OR] = 1'b1;
      else
      begin
        // The stop bit is in maj, so the word already sits in the shifter.
        d.rx_buf = q.ctl1[ASI_C1_M] ? q.rx_sh[9:1]
                                   : {1'b0, q.rx_sh[9:2]};
        d.ctl1[ASI_C1_RX8] = q.ctl1[ASI_C1_M] & q.rx_sh[9];
        d.status[ASI_ST_RXF] = 1'b1;
        d.status[ASI_ST_NF]  = q.rx_noise | noisy;
        d.status[ASI_ST_FE]  = !maj;
      end
    end

    // Single level interrupt from all enabled causes.
    d.irq = (q.status[ASI_ST_TXE] & q.ctl2[ASI_C2_TIE])
          | (q.status[ASI_ST_TC] & q.ctl2[ASI_C2_TX_DONE_IRQ_ON])
          | ((q.status[ASI_ST_RXF] | q.status[ASI_ST_OR])
             & q.ctl2[ASI_C2_RIE])
          | (q.status[ASI_ST_IDLE] & q.ctl2[ASI_C2_IDLE_IRQ_ON]);
  end

  // State register with clock enable.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q        <= '0;
      q.status <= ASI_RST_STATUS;
      q.ctl1   <= ASI_RST_CTL;
      q.ctl2   <= ASI_RST_CTL;
      q.out    <= 1'b1;
      q.oen_n  <= 1'b1;
      q.ones   <= 4'hF;
    end
    else if (clk_en)
      q <= d;
  end

  // Outputs straight from flip-flops; hreadyout and hresp are tied to constants.
  assign hrdata          = q.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign serial_out      = q.out;
  assign serial_out_en_n = q.oen_n;
  assign irq             = q.irq;

  // Empty flag drops only after status read then data write.
  property p_txe_clear;
    @(posedge hclk) disable iff (!hresetn)
    $fell(q.status[ASI_ST_TXE]) |-> $past(q.st_seen) && $past(q.wr_pend);
  endproperty
  a_txe_clear: assert property (p_txe_clear)
    else $error("empty flag cleared without sequence");

  // Full flag drops only after status read then data read.
  property p_rxf_clear;
    @(posedge hclk) disable iff (!hresetn)
    $fell(q.status[ASI_ST_RXF]) |-> $past(q.st_seen) && $past(q.rd_pend);
  endproperty
  a_rxf_clear: assert property (p_rxf_clear)
    else $error("full flag cleared without sequence");

  // Pin released exactly one edge after both enables drop.
  property p_release;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !q.ctl2[ASI_C2_TE] && !q.ctl2[ASI_C2_RE] |=> q.oen_n;
  endproperty
  a_release: assert property (p_release)
    else $error("pin not released");

  // Output high while transmitter is not sending.
  property p_idle_high;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.tx_st != ASI_TX_SEND |=> q.out;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("line not high when idle");

  // Overrun keeps the holding buffer unchanged.
  property p_overrun_keep;
    @(posedge hclk) disable iff (!hresetn)
    $rose(q.status[ASI_ST_OR]) |-> $stable(q.rx_buf);
  endproperty
  a_overrun_keep: assert property (p_overrun_keep)
    else $error("buffer lost on overrun");

  // Interrupt follows enabled empty flag one edge later.
  property p_irq_txe;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.status[ASI_ST_TXE] && q.ctl2[ASI_C2_TIE] |=> q.irq;
  endproperty
  a_irq_txe: assert property (p_irq_txe)
    else $error("missing empty interrupt");

  // Framing error rises only while the full flag is set.
  property p_fe_with_rxf;
    @(posedge hclk) disable iff (!hresetn)
    $rose(q.status[ASI_ST_FE]) |-> q.status[ASI_ST_RXF];
  endproperty
  a_fe_with_rxf: assert property (p_fe_with_rxf)
    else $error("framing error without full flag");

  // Break frame drives the line low.
  property p_break_low;
    @(posedge hclk) disable iff (!hresetn)
    clk_en && q.tx_st == ASI_TX_SEND && q.tx_brk |=> !q.out;
  endproperty
  a_break_low: assert property (p_break_low)
    else $error("break frame not low");
endmodule

// File: bench/asi_peer.sv
// Far-end serial equipment that sends frames into the block.
// Assumes one bit lasts BIT hclk cycles; the line idles at mark.
`timescale 1ns/1ps
module asi_peer #(
  parameter int BIT = 16 // Clock cycles per bit.
)(
  input  wire logic hclk,
  output logic      line
);
  initial line = 1'b1; // Mark level between frames.
  // Sends a low start, nb bits LSB first, then the given stop level.
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    line <= 1'b0;
    repeat (BIT) @(posedge hclk);
    for (int i = 0; i < nb; i++)
    begin
      line <= d[i];
      repeat (BIT) @(posedge hclk);
    end
    line <= stp;
    repeat (BIT) @(posedge hclk);
    line <= 1'b1;
    @(posedge hclk);
  endtask
endmodule

// File: bench/async_serial_interface_test.sv
// Self-checking bench for the serial interface block.
// Assumes the far-end model drives the receive line.
`timescale 1ns/1ps
module async_serial_interface_test;
  import asi_pkg::*;
  logic        hclk, hresetn, clk_en, hsel, hwrite, sin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, serial_out, serial_out_en_n, irq;
  logic [10:0] w;            // Sampled frame, start bit at index 0.
  int          gap;          // Cycles spent waiting for a start bit.
  int          n_errors = 0;
  int          total_checks = 0;

  asi_core uut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(sin),
    .serial_out(serial_out), .serial_out_en_n(serial_out_en_n),
    .irq(irq)
  );
  asi_peer peer (.hclk(hclk), .line(sin));

  // Free-running 250 MHz clock.
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // A wait that ran out ends the run.
  task automatic tmo;
    n_errors++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    summarize();
  endtask

  // One AHB-Lite single word transfer; read data lands in rd.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) tmo();
  endtask

  // Waits for a start bit, then samples nb data bits and the stop bit.
  task automatic grab(input int nb, input int bp);
    int n;
    n = 0;
    while (serial_out !== 1'b0 && n < 4000)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 4000) tmo();
    gap = n;
    w = '1;
    repeat (bp / 2) @(posedge hclk);
    w[0] = serial_out;
    for (int i = 1; i <= nb + 1; i++)
    begin
      repeat (bp) @(posedge hclk);
      w[i] = serial_out;
    end
  endtask

  // Reset values and an unmapped address.
  task automatic t_reset;
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd, {24'h0, ASI_RST_STATUS});
    check(serial_out_en_n, 1'b1);
    check(irq, 1'b0);
    xfer(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
  endtask

  // Idle frame, direct load, buffered load, flags, break, interrupt.
  task automatic t_tx;
    xfer(1'b1, ASI_OFF_CTL2, 32'h08);
    repeat (2) @(posedge hclk); // Enable reaches the pin one edge later.
    check(serial_out_en_n, 1'b0);
    check(serial_out, 1'b1);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    xfer(1'b1, ASI_OFF_DATA, 32'hA5);
    grab(8, 16);
    check(gap >= 140, 1'b1);
    check(w[9:0], {1'b1, 8'hA5, 1'b0});
    repeat (16) @(posedge hclk);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd[ASI_ST_TC], 1'b1);
    xfer(1'b1, ASI_OFF_DATA, 32'h3C);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd[ASI_ST_TXE], 1'b1);
    check(rd[ASI_ST_TC], 1'b0);
    xfer(1'b1, ASI_OFF_DATA, 32'hC3);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd[ASI_ST_TXE], 1'b0);
    grab(8, 16);
    check(w[9:0], {1'b1, 8'h3C, 1'b0});
    grab(8, 16);
    check(w[9:0], {1'b1, 8'hC3, 1'b0});
    xfer(1'b1, ASI_OFF_CTL2, 32'h09);
    grab(8, 16);
    check(w[9:0], 10'h000);
    xfer(1'b1, ASI_OFF_CTL2, 32'h88);
    gap = 0;
    while (serial_out !== 1'b1 && gap < 500)
    begin
      @(posedge hclk);
      gap++;
    end
    check(serial_out, 1'b1);
    repeat (4) @(posedge hclk);
    check(irq, 1'b1);
    xfer(1'b1, ASI_OFF_CTL2, 32'h08);
    repeat (2) @(posedge hclk);
    check(irq, 1'b0);
  endtask

  // Nine-bit transmit with the ninth bit set.
  task automatic t_tx9;
    xfer(1'b1, ASI_OFF_CTL1, 32'h50);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    xfer(1'b1, ASI_OFF_DATA, 32'h55);
    grab(9, 16);
    check(w, {1'b1, 1'b1, 8'h55, 1'b0});
    repeat (20) @(posedge hclk);
    xfer(1'b1, ASI_OFF_CTL2, 32'h00);
    repeat (2) @(posedge hclk); // Release reaches the pin one edge later.
    check(serial_out_en_n, 1'b1);
  endtask

  // Reception, overrun, break and nine-bit reception.
  task automatic t_rx;
    xfer(1'b1, ASI_OFF_CTL1, 32'h00);
    xfer(1'b1, ASI_OFF_CTL2, 32'h24);
    peer.send(9'h096, 8, 1'b1);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd[ASI_ST_RXF], 1'b1);
    check(irq, 1'b1);
    xfer(1'b0, ASI_OFF_DATA, 32'h0);
    check(rd, 32'h96);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd[ASI_ST_RXF], 1'b0);
    check(irq, 1'b0);
    peer.send(9'h011, 8, 1'b1);
    peer.send(9'h022, 8, 1'b1);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd[ASI_ST_OR], 1'b1);
    xfer(1'b0, ASI_OFF_DATA, 32'h0);
    check(rd, 32'h11);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd[ASI_ST_OR], 1'b0);
    peer.send(9'h000, 8, 1'b0);
    repeat (40) @(posedge hclk);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd[ASI_ST_FE], 1'b1);
    check(rd[ASI_ST_IDLE], 1'b0);
    check(rd[ASI_ST_RXF], 1'b1);
    xfer(1'b0, ASI_OFF_DATA, 32'h0);
    check(rd, 32'h00);
    xfer(1'b1, ASI_OFF_CTL1, 32'h10);
    peer.send(9'h1A5, 9, 1'b1);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    xfer(1'b0, ASI_OFF_DATA, 32'h0);
    check(rd, 32'hA5);
    xfer(1'b0, ASI_OFF_CTL1, 32'h0);
    check(rd[ASI_C1_RX8], 1'b1);
    // Eleven high bit times after the nine-bit frame make an idle frame.
    repeat (180) @(posedge hclk);
    xfer(1'b0, ASI_OFF_STATUS, 32'h0);
    check(rd[ASI_ST_IDLE], 1'b1);
  endtask

  // Reset, then the scenarios in turn.
  initial
  begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_tx();
    t_tx9();
    t_rx();
    summarize();
  end
endmodule
